/* File: mrp_defs.vh */
`ifndef MRP_DEFS_VH
`define MRP_DEFS_VH
`define MRP_OFF_DUTY0      8'h28
`define MRP_OFF_DUTY7      8'h44
`define MRP_OFF_HOLE       8'h3c
`define MRP_OFF_FINE       8'h48
`define MRP_OFF_COARSE     8'h4c
`define MRP_OFF_PIN_SEL    8'h54
`define MRP_OFF_WIDE_SEL   8'h58
`define MRP_OFF_POLARITY   8'h5c
`define MRP_OFF_STATUS     8'h60
`define MRP_POL_SEVEN      0
`define MRP_POL_SIX        1
`define MRP_POL_WIDE       2
`define MRP_RST_DUTY       7'h00
`define MRP_RST_FINE       7'h7f
`define MRP_RST_COARSE     7'h00
`define MRP_RST_PIN_SEL    8'h00
`define MRP_RST_POLARITY   3'h0
`define MRP_PRESCALE       3
`define MRP_RESP_OKAY      2'h0
`define MRP_RESP_SLVERR    2'h2
`endif

/* File: mrp_narrow_chan.v */
module mrp_narrow_chan #(
  parameter BITS = 7
) (
  input  wire            clk_i,
  input  wire            srst_i,
  input  wire            tick_i,
  input  wire [BITS-1:0] duty_i,
  input  wire            polarity_i,
  input  wire            pin_select_i,
  input  wire            port_line_i,
  output reg             pin_o
);
  reg [BITS-1:0] count;

  // wraps every 2**BITS ticks: 64*3=192, 128*3=384 crystal periods
  always @(posedge clk_i) begin
    if (srst_i) begin
      count <= {BITS{1'b0}};
      pin_o <= 1'b0;
    end else begin
      if (tick_i) begin
        count <= count + {{(BITS-1){1'b0}}, 1'b1};
      end
      if (pin_select_i) begin
        pin_o <= (count < duty_i) ^ polarity_i;
      end else begin
        pin_o <= port_line_i;
      end
    end
  end
endmodule

/* File: mrp_pwm_asserts.sv */
module mrp_pwm_chk (
  input logic        clk_i,
  input logic        srst_i,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [7:0]  s_axi_araddr,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [7:0]  port_line_i,
  input logic [7:0]  channel_pin_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_write_answered: assert property (both_taken |=> s_axi_bvalid)
    else $error("write response missing");
  chk_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_bvalid_clears: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_read_answered: assert property (read_taken |=> s_axi_rvalid)
    else $error("read data missing");
  chk_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_hole_refused: assert property (read_taken and s_axi_araddr == 8'h3c |=>
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unused latch slot answered");
  // pin five has no channel: two sync flops, no output register
  chk_hole_follows: assert property (!$past(srst_i) && !$past(srst_i, 2) |->
    channel_pin_o[5] == $past(port_line_i[5], 2))
    else $error("unused channel pin not following port line");
endmodule
bind mrp_pwm_top mrp_pwm_chk u_chk (
  .clk_i(clk_i), .srst_i(srst_i), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .port_line_i(port_line_i), .channel_pin_o(channel_pin_o)
);

/* File: mrp_pwm_top.v */
`include "mrp_defs.vh"
module mrp_pwm_top (
  input  wire        clk_i,
  input  wire        srst_i,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [7:0]  port_line_i,
  input  wire        port_line_thirteen_i,
  output wire [7:0]  channel_pin_o,
  output wire        wide_channel_out_o
);
  reg  [6:0]  duty [0:7];
  reg  [6:0]  fine_select_latch;
  reg  [6:0]  coarse_width_latch;
  reg  [13:0] wide_working_register;
  reg  [7:0]  channel_pin_select;
  reg         wide_channel_pin_select;
  reg  [2:0]  polarity;
  reg  [1:0]  prescale;
  reg         tick;
  reg  [7:0]  aw_addr;
  reg         aw_held;
  reg  [31:0] w_data;
  reg         w_held;
  wire [13:0] wide_count;
  integer     i;

  // write side takes address and data in either order, answers after both
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire       aw_now   = aw_held | (s_axi_awvalid & s_axi_awready);
  wire       w_now    = w_held | (s_axi_wvalid & s_axi_wready);
  wire [7:0] wr_addr  = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0] wr_strb  = s_axi_wstrb;
  wire       do_write = aw_now && w_now && !s_axi_bvalid;
  reg  [3:0] w_strb;
  wire [3:0] eff_strb = w_held ? w_strb : wr_strb;

  function is_duty;
    input [7:0] a;
    begin
      // latch offsets 10..17 times four, slot 15 absent
      is_duty = (a >= `MRP_OFF_DUTY0) && (a <= `MRP_OFF_DUTY7) && (a[1:0] == 2'b00)
                && (a != `MRP_OFF_HOLE);
    end
  endfunction

  function wr_known;
    input [7:0] a;
    begin
      wr_known = is_duty(a) || a == `MRP_OFF_FINE || a == `MRP_OFF_COARSE
                 || a == `MRP_OFF_PIN_SEL || a == `MRP_OFF_WIDE_SEL
                 || a == `MRP_OFF_POLARITY;
    end
  endfunction

  // slot index into duty array: (offset-0x28)/4, channel 5 never written
  wire [2:0] wr_slot = wr_addr[4:2] + 3'h6;
  wire [2:0] rd_slot = s_axi_araddr[4:2] + 3'h6;

  // xtal/3 prescaler shared by all channels
  always @(posedge clk_i) begin
    if (srst_i) begin
      prescale <= 2'h0;
      tick     <= 1'b0;
    end else begin
      prescale <= (prescale == `MRP_PRESCALE - 1) ? 2'h0 : prescale + 2'h1;
      tick     <= (prescale == `MRP_PRESCALE - 1);
    end
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      for (i = 0; i < 8; i = i + 1) begin
        duty[i] <= `MRP_RST_DUTY;
      end
      fine_select_latch       <= `MRP_RST_FINE;
      coarse_width_latch      <= `MRP_RST_COARSE;
      wide_working_register   <= {`MRP_RST_COARSE, `MRP_RST_FINE};
      channel_pin_select      <= `MRP_RST_PIN_SEL;
      wide_channel_pin_select <= 1'b0;
      polarity                <= `MRP_RST_POLARITY;
      aw_held                 <= 1'b0;
      aw_addr                 <= 8'h00;
      w_held                  <= 1'b0;
      w_data                  <= 32'h00000000;
      w_strb                  <= 4'h0;
      s_axi_bvalid            <= 1'b0;
      s_axi_bresp             <= `MRP_RESP_OKAY;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known(wr_addr) ? `MRP_RESP_OKAY : `MRP_RESP_SLVERR;
        if (eff_strb[0]) begin
          if (is_duty(wr_addr)) begin
            duty[wr_slot] <= wr_data[6:0];
          end
          if (wr_addr == `MRP_OFF_FINE) begin
            fine_select_latch     <= wr_data[6:0];
            wide_working_register <= {coarse_width_latch, wr_data[6:0]};
          end
          if (wr_addr == `MRP_OFF_COARSE) begin
            coarse_width_latch    <= wr_data[6:0];
            wide_working_register <= {wr_data[6:0], fine_select_latch};
          end
          if (wr_addr == `MRP_OFF_PIN_SEL) begin
            channel_pin_select <= wr_data[7:0] & 8'hdf;
          end
          if (wr_addr == `MRP_OFF_WIDE_SEL) begin
            wide_channel_pin_select <= wr_data[0];
          end
          if (wr_addr == `MRP_OFF_POLARITY) begin
            polarity <= wr_data[2:0];
          end
        end
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
      end
    end
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `MRP_RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else if (s_axi_arvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `MRP_RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
      if (is_duty(s_axi_araddr)) begin
        s_axi_rdata <= {25'h0000000, duty[rd_slot]};
      end else if (s_axi_araddr == `MRP_OFF_FINE) begin
        s_axi_rdata <= {25'h0000000, fine_select_latch};
      end else if (s_axi_araddr == `MRP_OFF_COARSE) begin
        s_axi_rdata <= {25'h0000000, coarse_width_latch};
      end else if (s_axi_araddr == `MRP_OFF_PIN_SEL) begin
        s_axi_rdata <= {24'h000000, channel_pin_select};
      end else if (s_axi_araddr == `MRP_OFF_WIDE_SEL) begin
        s_axi_rdata <= {31'h00000000, wide_channel_pin_select};
      end else if (s_axi_araddr == `MRP_OFF_POLARITY) begin
        s_axi_rdata <= {29'h00000000, polarity};
      end else if (s_axi_araddr == `MRP_OFF_STATUS) begin
        // live counter and working register, read-only
        s_axi_rdata <= {4'h0, wide_working_register, wide_count};
      end else begin
        s_axi_rresp <= `MRP_RESP_SLVERR;
      end
    end
  end

  // port lines: two-flop synchronisers before use
  reg [8:0] port_meta;
  reg [8:0] port_sync;
  always @(posedge clk_i) begin
    if (srst_i) begin
      port_meta <= 9'h000;
      port_sync <= 9'h000;
    end else begin
      port_meta <= {port_line_thirteen_i, port_line_i};
      port_sync <= port_meta;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_chan
      if (g == 5) begin : g_none
        // no channel five: pin stays a plain port line
        assign channel_pin_o[g] = port_sync[g];
      end else if (g < 4) begin : g_seven
        mrp_narrow_chan #(.BITS(7)) u_ch (
          .clk_i        (clk_i),
          .srst_i       (srst_i),
          .tick_i       (tick),
          .duty_i       (duty[g]),
          .polarity_i   (polarity[`MRP_POL_SEVEN]),
          .pin_select_i (channel_pin_select[g]),
          .port_line_i  (port_sync[g]),
          .pin_o        (channel_pin_o[g])
        );
      end else begin : g_six
        mrp_narrow_chan #(.BITS(6)) u_ch (
          .clk_i        (clk_i),
          .srst_i       (srst_i),
          .tick_i       (tick),
          .duty_i       (duty[g][5:0]),
          .polarity_i   (polarity[`MRP_POL_SIX]),
          .pin_select_i (channel_pin_select[g]),
          .port_line_i  (port_sync[g]),
          .pin_o        (channel_pin_o[g])
        );
      end
    end
  endgenerate

  mrp_wide_chan u_wide (
    .clk_i        (clk_i),
    .srst_i       (srst_i),
    .tick_i       (tick),
    .working_i    (wide_working_register),
    .polarity_i   (polarity[`MRP_POL_WIDE]),
    .pin_select_i (wide_channel_pin_select),
    .port_line_i  (port_sync[8]),
    .pin_o        (wide_channel_out_o),
    .count_o      (wide_count)
  );
endmodule

/* File: mrp_rc_load.sv */
module mrp_rc_load (
  input  logic        clk_i,
  input  logic        clr_i,
  input  logic        pin_i,
  output logic [31:0] level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // charge stands for integrated voltage: high cycles seen since clear
  always @(posedge clk_i) level_o <= clr_i ? 0 : level_o + pin_i;
endmodule

/* File: mrp_wide_chan.v */
module mrp_wide_chan (
  input  wire        clk_i,
  input  wire        srst_i,
  input  wire        tick_i,
  input  wire [13:0] working_i,
  input  wire        polarity_i,
  input  wire        pin_select_i,
  input  wire        port_line_i,
  output reg         pin_o,
  output reg  [13:0] count_o
);
  wire [6:0] step      = count_o[6:0];
  wire [6:0] subperiod = count_o[13:7];
  wire [6:0] coarse_v  = working_i[13:7];
  wire [6:0] fine_v    = working_i[6:0];
  reg        coarse_out;
  reg        fine_out;
  reg        select_hit;
  integer    b;

  // bit b clear selects subperiods whose lowest set bit is bit (6-b); 0 never selected
  always @* begin
    select_hit = 1'b0;
    for (b = 0; b < 7; b = b + 1) begin
      if (!fine_v[b] && subperiod[6-b] && (subperiod & ((7'h01 << (6-b)) - 7'h01)) == 7'h00)
        select_hit = 1'b1;
    end
  end

  always @* begin
    coarse_out = (step > coarse_v);
    fine_out   = select_hit && (step == 7'h00);
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      count_o <= 14'h0000;
      pin_o   <= 1'b0;
    end else begin
      if (tick_i) begin
        count_o <= count_o + 14'h0001;
      end
      if (pin_select_i) begin
        pin_o <= (coarse_out | fine_out) ^ polarity_i;
      end else begin
        pin_o <= port_line_i;
      end
    end
  end
endmodule

/* File: testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DUTY_IDX = 10;
  localparam int FINE_IDX = 18;
  localparam int COARSE_IDX = 19;
  logic        clk_i = 0, srst_i = 1, clr = 0, port13 = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, port_line = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  psel = 4'h0;
  wire         awready, wready, bvalid, arready, rvalid, wide;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [7:0]  pins;
  logic [31:0] level;
  int          mismatches = 0, num_checks = 0;
  always #5 clk_i = ~clk_i;
  mrp_pwm_top dut (.clk_i(clk_i), .srst_i(srst_i), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port_line_i(port_line), .port_line_thirteen_i(port13), .channel_pin_o(pins),
    .wide_channel_out_o(wide));
  mrp_rc_load load (.clk_i(clk_i), .clr_i(clr), .pin_i(psel[3] ? wide : pins[psel[2:0]]),
    .level_o(level));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ta, tw;
    @(posedge clk_i);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1;
    ta = 0; tw = 0;
    while (!(ta && tw)) begin
      @(posedge clk_i);
      if (awready === 1'b1 && !ta) begin ta = 1; awvalid <= 0; end
      if (wready === 1'b1 && !tw) begin tw = 1; wvalid <= 0; end
    end
    while (bvalid !== 1'b1) @(posedge clk_i);
    // late ready exercises the slave holding its answer
    bready <= 1;
    @(posedge clk_i);
    bready <= 0;
    cmp({30'h0, bresp}, 32'h0, "write resp");
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    araddr <= a; arvalid <= 1;
    do @(posedge clk_i); while (arready !== 1'b1);
    arvalid <= 0;
    while (rvalid !== 1'b1) @(posedge clk_i);
    rready <= 1;
    @(posedge clk_i);
    d = rdata; r = rresp; rready <= 0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    cmp(d, e, "read data");
    cmp({30'h0, r}, {30'h0, er}, "read resp");
  endtask
  task automatic meas(input logic [3:0] s, input int n, input int exp);
    @(posedge clk_i);
    psel <= s;
    repeat (12) @(posedge clk_i);
    clr <= 1;
    @(posedge clk_i);
    clr <= 0;
    repeat (n) @(posedge clk_i);
    #1 cmp(level, exp, "high cycles");
  endtask
  task automatic t_reset;
    rdchk(8'(4 * DUTY_IDX), 32'h0, 2'h0);
    rdchk(8'(4 * FINE_IDX), 32'h7f, 2'h0);
    rdchk(8'(4 * COARSE_IDX), 32'h0, 2'h0);
    rdchk(8'h5c, 32'h0, 2'h0);
    rdchk(8'(4 * 15), 32'h0, 2'h2);
  endtask
  task automatic t_narrow;
    int c, per;
    for (int i = 0; i < 2; i++) begin
      c = i ? 4 : 0;
      per = i ? 192 : 384;
      wr(8'(4 * (DUTY_IDX + c)), 32'h5);
      wr(8'h54, 32'h1 << c);
      meas(4'(c), per, 15);
      wr(8'h5c, i ? 32'h2 : 32'h1);
      meas(4'(c), per, per - 15);
      wr(8'h5c, 32'h0);
    end
    wr(8'h54, 32'h0);
  endtask
  task automatic t_port;
    port_line <= 8'h22;
    port13 <= 1;
    repeat (6) @(posedge clk_i);
    #1 cmp({31'h0, pins[1]}, 32'h1, "port line");
    cmp({31'h0, pins[5]}, 32'h1, "hole pin");
    cmp({31'h0, wide}, 32'h1, "wide port line");
    wr(8'h54, 32'hff);
    rdchk(8'h54, 32'hdf, 2'h0);
    repeat (6) @(posedge clk_i);
    #1 cmp({31'h0, pins[1]}, 32'h0, "zero duty pin");
    cmp({28'h0, pins[7:6], pins[3:2]}, 32'h0, "zero duty pins");
    cmp({31'h0, pins[5]}, 32'h1, "hole pin selected");
    wr(8'h54, 32'h0);
    port_line <= 8'h00;
    port13 <= 0;
  endtask
  task automatic t_wide;
    logic [31:0] d;
    logic [1:0]  r;
    wr(8'(4 * COARSE_IDX), 32'h64);
    rd(8'h60, d, r);
    cmp({18'h0, d[27:14]}, {18'h0, 7'h64, 7'h7f}, "working reg");
    wr(8'(4 * FINE_IDX), 32'h7a);
    rd(8'h60, d, r);
    cmp({18'h0, d[27:14]}, {18'h0, 7'h64, 7'h7a}, "working reg");
    wr(8'h58, 32'h1);
    // coarse 27 steps per subperiod plus fine pulses in 16,48,64,80,112
    meas(4'h8, 49152, 128 * 81 + 5 * 3);
    wr(8'(4 * FINE_IDX), 32'h7f);
    meas(4'h8, 384, 81);
    wr(8'h5c, 32'h4);
    meas(4'h8, 384, 384 - 81);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    srst_i <= 0;
    t_reset;
    t_narrow;
    t_port;
    t_wide;
    wrap_up;
  end
  // run needs about 51k cycles, most of it one full fine cycle
  initial begin
    repeat (80000) @(posedge clk_i);
    mismatches++;
    $display("BAD %0t watchdog expired", $time);
    wrap_up;
  end
endmodule
